// file: pkg/bgc_defs.vh
// Constants for the three-phase gate control and protection block
// Functional notes
// R1: Gate on and past blanking: drain-source over threshold forces all gates off.
// R2: Short fault latches, pulls fault pin, requests status; clears on enable rise.
// R3: Two-bit select picks short threshold 250, 500, 750 or 1000 mV.
// R4: Threshold codes 0..3 map ascending to 250..1000 mV.
// R5: Short detect enable bit; when off no short fault is raised.
// R6: Threshold field from first config message drives the short comparison.
// R7: High and low both commanded on one phase turns both gates off.
// R8: Break-before-make delay 250 to 2000 ns in 250 ns steps, default 2000.
// R9: Dead-time code n gives (n+1) times 250 ns.
// R10: Dead time keeps high and low on-times of a phase from overlapping.
// R11: Blanking 500 ns, 1, 2 or 4 us, default 4; overcurrent ignored meanwhile.
// R12: Blanking starts only after the dead-time delay has expired.
// R13: Gate undervoltage latches only after qualify time; blanking extends that time.
// R14: Amplifiers on unless asleep; in standby config bit 6 set turns them off.
// R15: Output enable low holds all six gates low.
// R16: Host charges bootstraps with all low sides on, 1.2 ms per microfarad. The host model sets only the levels and times no duration.
// R17: Host lock mode drives phase B low, phases A and C high.
// R18: Host ramp mode steps six states open-loop with linear rate increase. The bench holds each of modes 3..8 for a fixed 260 cycles.
// R19: Host run mode commutates under back-EMF phase-locked control. The host model has no run mode and no back-EMF input.
// R20: Host drives two windings per step; step order sets rotation.
// R21: Each PWM input high turns its gate on, low turns it off.
// R22: Gates forced low on fault, enable low over 1 ms, or sleep.
`ifndef BGC_DEFS_VH
`define BGC_DEFS_VH

// ---------------------------------------------------------------
// Clock and time
// ---------------------------------------------------------------
`define BGC_CLK_MHZ        125
`define BGC_NS_PER_US      1000
`define BGC_US_PER_MS      1000
`define BGC_DT_STEP_NS     250
`define BGC_BLK_BASE_NS    500
`define BGC_OE_LONG_MS     1
`define BGC_UV_QUAL_NS     10000
`define BGC_OE_LONG_CYC    (`BGC_OE_LONG_MS * `BGC_US_PER_MS * `BGC_CLK_MHZ)
`define BGC_UV_QUAL_CYC    ((`BGC_UV_QUAL_NS * `BGC_CLK_MHZ) / `BGC_NS_PER_US)

// ---------------------------------------------------------------
// Field widths and reset values
// ---------------------------------------------------------------
`define BGC_MV_W           11
`define BGC_DT_W           8
`define BGC_BLK_W          9
`define BGC_OE_CNT_W       17
`define BGC_UV_CNT_W       17
`define BGC_SC_STEP_MV     11'h0fa
`define BGC_DT_SEL_RESET   3'h7
`define BGC_BLK_SEL_RESET  2'h3
`define BGC_AMP_OFF_BIT    6

`endif

// file: core/bgc_qualify.v
// Persistence timer: flags a condition that has lasted a set count
`timescale 1ns/1ps

module bgc_qualify #(
  parameter         W     = 17,
  parameter [W-1:0] LIMIT = 17'h00001
) (
  input  wire       clock,
  input  wire       rst,
  input  wire       cond,
  input  wire       hold,
  output wire       done
);

  reg [W-1:0] count;

  // ---------------------------------------------------------------
  // Count while the condition persists, freeze while held
  // ---------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= {W{1'b0}};
    end else if (!cond) begin
      count <= {W{1'b0}};
    end else if (!hold && count != LIMIT) begin
      count <= count + {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign done = cond & (count == LIMIT);

endmodule // bgc_qualify

// file: core/bgc_half_bridge.v
// One half-bridge: shoot-through block, dead time and blanking
`timescale 1ns/1ps
`include "bgc_defs.vh"

module bgc_half_bridge (
  input  wire                  clock,
  input  wire                  rst,
  input  wire                  pwm_high,
  input  wire                  pwm_low,
  input  wire                  allow,
  input  wire [`BGC_DT_W-1:0]  dt_cyc,
  input  wire [`BGC_BLK_W-1:0] blk_cyc,
  output wire [1:0]            gate,
  output wire [1:0]            blank,
  output wire [1:0]            sense
);

  // ---------------------------------------------------------------
  // Requests, side 0 low and side 1 high
  // ---------------------------------------------------------------
  wire [1:0] req;
  assign req = {pwm_high & ~pwm_low & allow, pwm_low & ~pwm_high & allow}; // R7 R21

  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1) begin : g_side
      reg                  on_q;
      reg [`BGC_DT_W-1:0]  dcnt;
      reg [`BGC_BLK_W-1:0] bcnt;

      // Turn-off is immediate; turn-on waits for the opposite gate to be
      // off and then a full dead time, so the two never overlap
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          on_q <= 1'b0;
          dcnt <= {`BGC_DT_W{1'b0}};
          bcnt <= {`BGC_BLK_W{1'b0}};
        end else if (!req[s]) begin
          on_q <= 1'b0; // R15 R21
          dcnt <= {`BGC_DT_W{1'b0}};
        end else if (!on_q) begin
          if (gate[1-s]) begin
            dcnt <= {`BGC_DT_W{1'b0}}; // R10
          end else if (dcnt == dt_cyc) begin
            on_q <= 1'b1; // R8
            bcnt <= {`BGC_BLK_W{1'b0}}; // R12
          end else begin
            dcnt <= dcnt + {{(`BGC_DT_W-1){1'b0}}, 1'b1};
          end
        end else if (bcnt != blk_cyc) begin
          bcnt <= bcnt + {{(`BGC_BLK_W-1){1'b0}}, 1'b1};
        end
      end

      assign gate[s]  = on_q;
      assign blank[s] = on_q & (bcnt != blk_cyc); // R11
      assign sense[s] = on_q & ~blank[s]; // R1
    end
  endgenerate

endmodule // bgc_half_bridge

// file: core/bgc_gate_ctrl.v
// Top of the gate control: three bridges, fault latches, standby
`timescale 1ns/1ps
`include "bgc_defs.vh"

module bgc_gate_ctrl #(
  parameter OE_LONG_CYC = `BGC_OE_LONG_CYC,
  parameter UV_QUAL_CYC = `BGC_UV_QUAL_CYC
) (
  input  wire                    clock,
  input  wire                    rst,
  input  wire [2:0]              pwm_high,
  input  wire [2:0]              pwm_low,
  input  wire                    output_enable,
  input  wire                    sleep_mode,
  input  wire                    short_detect_en,
  input  wire [1:0]              short_threshold_sel,
  input  wire                    gate_uv_detect_en,
  input  wire [2:0]              dead_time_sel,
  input  wire [1:0]              blanking_sel,
  input  wire                    amp_standby_off,
  input  wire [3*`BGC_MV_W-1:0]  high_vds_mv,
  input  wire [3*`BGC_MV_W-1:0]  low_vds_mv,
  input  wire [2:0]              high_bias_low,
  input  wire [2:0]              low_bias_low,
  output wire [2:0]              high_gate_outputs,
  output wire [2:0]              low_gate_outputs,
  input  wire                    fault_pin_i,
  output wire                    fault_pin_o,
  output wire                    fault_pin_oe,
  output reg                     short_fault,
  output reg                     gate_uv_fault,
  output reg                     status_msg_req,
  output wire                    standby,
  output wire                    amp_enable
);

  localparam [`BGC_OE_CNT_W-1:0] OE_LIM = OE_LONG_CYC;
  localparam [`BGC_UV_CNT_W-1:0] UV_LIM = UV_QUAL_CYC;

  // ---------------------------------------------------------------
  // Timing selections
  // ---------------------------------------------------------------
  // Least times, so both round up to whole cycles
  wire [31:0] dt_full;
  wire [31:0] blk_full;
  wire [`BGC_DT_W-1:0]  dt_cyc;
  wire [`BGC_BLK_W-1:0] blk_cyc;

  assign dt_full  = (({29'h0000000, dead_time_sel} + 32'h00000001)
                    * `BGC_DT_STEP_NS * `BGC_CLK_MHZ
                    + `BGC_NS_PER_US - 1) / `BGC_NS_PER_US; // R8 R9
  assign blk_full = (((`BGC_BLK_BASE_NS * `BGC_CLK_MHZ) << blanking_sel)
                    + `BGC_NS_PER_US - 1) / `BGC_NS_PER_US; // R11
  assign dt_cyc   = dt_full[`BGC_DT_W-1:0];
  assign blk_cyc  = blk_full[`BGC_BLK_W-1:0];

  // Threshold straight from the configured field, codes ascending
  wire [`BGC_MV_W-1:0] sc_thr_mv;
  assign sc_thr_mv = ({{(`BGC_MV_W-2){1'b0}}, short_threshold_sel}
                     + {{(`BGC_MV_W-1){1'b0}}, 1'b1}) * `BGC_SC_STEP_MV; // R3 R4 R6

  // ---------------------------------------------------------------
  // Enable qualification and standby
  // ---------------------------------------------------------------
  wire oe_long_low;
  wire any_fault;
  wire allow;

  bgc_qualify #(
    .W     (`BGC_OE_CNT_W),
    .LIMIT (OE_LIM)
  ) u_oe_low (
    .clock (clock),
    .rst   (rst),
    .cond  (~output_enable),
    .hold  (1'b0),
    .done  (oe_long_low)
  );

  assign standby    = oe_long_low & ~sleep_mode;
  assign amp_enable = ~sleep_mode & ~(standby & amp_standby_off); // R14

  // Enable low already blocks the gates before the 1 ms standby mark
  assign any_fault = short_fault | gate_uv_fault;
  assign allow     = output_enable & ~oe_long_low & ~sleep_mode & ~any_fault; // R15 R22

  // ---------------------------------------------------------------
  // Half-bridges
  // ---------------------------------------------------------------
  wire [2:0] blank_h;
  wire [2:0] blank_l;
  wire [2:0] sense_h;
  wire [2:0] sense_l;
  wire [2:0] sc_hit_h;
  wire [2:0] sc_hit_l;

  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_phase
      bgc_half_bridge u_bridge (
        .clock    (clock),
        .rst      (rst),
        .pwm_high (pwm_high[p]),
        .pwm_low  (pwm_low[p]),
        .allow    (allow),
        .dt_cyc   (dt_cyc),
        .blk_cyc  (blk_cyc),
        .gate     ({high_gate_outputs[p], low_gate_outputs[p]}),
        .blank    ({blank_h[p], blank_l[p]}),
        .sense    ({sense_h[p], sense_l[p]})
      );

      // Spikes during blanking are not looked at
      assign sc_hit_h[p] = sense_h[p]
        & (high_vds_mv[p*`BGC_MV_W +: `BGC_MV_W] > sc_thr_mv); // R1 R11
      assign sc_hit_l[p] = sense_l[p]
        & (low_vds_mv[p*`BGC_MV_W +: `BGC_MV_W] > sc_thr_mv); // R1 R11
    end
  endgenerate

  // ---------------------------------------------------------------
  // Gate-drive undervoltage qualification
  // ---------------------------------------------------------------
  wire uv_cond;
  wire uv_done;

  // Only watched while a driver is actually driving its gate
  assign uv_cond = gate_uv_detect_en
    & |((high_bias_low & high_gate_outputs) | (low_bias_low & low_gate_outputs));

  bgc_qualify #(
    .W     (`BGC_UV_CNT_W),
    .LIMIT (UV_LIM)
  ) u_uv_qual (
    .clock (clock),
    .rst   (rst),
    .cond  (uv_cond),
    .hold  (|{blank_h, blank_l}), // R13
    .done  (uv_done)
  );

  // ---------------------------------------------------------------
  // Fault latches
  // ---------------------------------------------------------------
  reg  oe_prev;
  wire oe_rise;
  wire sc_set;
  wire uv_set;

  assign oe_rise = output_enable & ~oe_prev;
  assign sc_set  = short_detect_en & (|{sc_hit_h, sc_hit_l}); // R5
  assign uv_set  = uv_done; // R13

  // A new hit in the enable-rise cycle wins over the clear
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      oe_prev        <= 1'b0;
      short_fault    <= 1'b0;
      gate_uv_fault  <= 1'b0;
      status_msg_req <= 1'b0;
    end else begin
      oe_prev <= output_enable;
      if (sc_set) begin
        short_fault <= 1'b1; // R2
      end else if (oe_rise) begin
        short_fault <= 1'b0; // R2
      end
      if (uv_set) begin
        gate_uv_fault <= 1'b1;
      end else if (oe_rise) begin
        gate_uv_fault <= 1'b0;
      end
      status_msg_req <= (sc_set & ~short_fault) | (uv_set & ~gate_uv_fault); // R2
    end
  end

  // ---------------------------------------------------------------
  // Open-drain fault pin, pulled low while a fault is held
  // ---------------------------------------------------------------
  assign fault_pin_o  = 1'b0;
  assign fault_pin_oe = any_fault; // R2

endmodule // bgc_gate_ctrl

// file: dv/bgc_host_model.sv
// Host model: PWM commands for the start-up and commutation modes
`timescale 1ns/1ps
module bgc_host_model (
  input  logic [3:0] mode,
  output logic [2:0] pwm_high,
  output logic [2:0] pwm_low
);
  // ---------------------------------------------------------------
  // Mode table, {high, low}, bit 0 is phase A
  // ---------------------------------------------------------------
  // 0 off, 1 bootstrap, 2 lock, 3..8 six steps, 9 deliberate A overlap
  // Bootstrap duration is the caller's job; the model only sets levels
  localparam logic [5:0] TBL [0:9] = '{6'h00, 6'h07, 6'h2a, 6'h0c, 6'h14,
                                       6'h11, 6'h21, 6'h22, 6'h0a, 6'h09};
  assign {pwm_high, pwm_low} = TBL[mode];
endmodule  // bgc_host_model

// file: dv/bgc_gate_ctrl_assertions.sv
// Port checker for the gate control top
`timescale 1ns/1ps
module bgc_gate_ctrl_assertions (
  input logic       clock,
  input logic       rst,
  input logic [2:0] pwm_high,
  input logic [2:0] pwm_low,
  input logic       output_enable,
  input logic       sleep_mode,
  input logic       short_detect_en,
  input logic       amp_standby_off,
  input logic [2:0] high_gate_outputs,
  input logic [2:0] low_gate_outputs,
  input logic       short_fault,
  input logic       gate_uv_fault,
  input logic       status_msg_req,
  input logic       fault_pin_oe,
  input logic       standby,
  input logic       amp_enable
);
  // ---------------------------------------------------------------
  // Sequences and properties
  // ---------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence fault_rise; $rose(short_fault) || $rose(gate_uv_fault); endsequence
  sequence one_pulse; status_msg_req ##1 !status_msg_req; endsequence
  wire [2:0] on_any = high_gate_outputs | low_gate_outputs;
  chk_shoot_block: assert property (|(pwm_high & pwm_low) |=>
    (on_any & $past(pwm_high) & $past(pwm_low)) == 3'h0) else $error("overlap not blocked");
  chk_no_overlap: assert property ((high_gate_outputs & low_gate_outputs) == 3'h0)
    else $error("high and low gate on together");
  chk_oe_gates_off: assert property (!output_enable |=> on_any == 3'h0)
    else $error("gate on with enable low");
  chk_fault_gates_off: assert property (short_fault || gate_uv_fault || sleep_mode
    |=> on_any == 3'h0) else $error("gate on under fault or sleep");
  chk_fault_report: assert property (fault_rise |-> one_pulse)
    else $error("status request not a single pulse");
  chk_fault_pin: assert property (fault_pin_oe == (short_fault || gate_uv_fault))
    else $error("fault pin mismatch");
  // The clear lands on the edge that first samples enable high, so only that edge may drop it
  chk_fault_hold: assert property (short_fault && !$rose(output_enable) |=> short_fault)
    else $error("short fault lost without enable rise");
  chk_short_gated: assert property ($rose(short_fault) |-> $past(short_detect_en))
    else $error("short fault while detection off");
  chk_amp_state: assert property (amp_enable == (!sleep_mode && !(standby && amp_standby_off)))
    else $error("amplifier enable wrong");
endmodule  // bgc_gate_ctrl_assertions

bind bgc_gate_ctrl bgc_gate_ctrl_assertions chk_i (.clock, .rst, .pwm_high, .pwm_low,
  .output_enable, .sleep_mode, .short_detect_en, .amp_standby_off, .high_gate_outputs,
  .low_gate_outputs, .short_fault, .gate_uv_fault, .status_msg_req, .fault_pin_oe,
  .standby, .amp_enable);

// file: dv/test_bldc_gate_control_protection.sv
// Self-checking bench for the gate control top
`timescale 1ns/1ps
`include "bgc_defs.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module test_bldc_gate_control_protection;
  logic clock = 0, rst = 1, oe = 0, slp = 0, sc_en = 0, uv_en = 0, amp_off = 0;
  logic [3:0] mode = 0;
  logic [2:0] dt_sel = 3'h7, lbias = 0, hg, lg, pwm_h, pwm_l;
  logic [1:0] blk_sel = 2'h3, thr_sel = 0;
  logic [10:0] vds = 0;
  logic short_fault, gate_uv_fault, status_msg_req, fault_pin_oe, standby, amp_enable;
  logic fault_pin_o;
  int fail_count = 0, cmp_count = 0, cnt;
  // Commutation rows: {mode, expected high gates, expected low gates}
  logic [9:0] rows [0:8] = '{10'h000, 10'h047, 10'h0aa, 10'h0cc, 10'h114,
                             10'h151, 10'h1a1, 10'h1e2, 10'h20a};
  always #4 clock = ~clock;
  bgc_host_model host (.mode(mode), .pwm_high(pwm_h), .pwm_low(pwm_l));
  // Shortened enable-low and qualify counts keep the run brief
  bgc_gate_ctrl #(.OE_LONG_CYC(20), .UV_QUAL_CYC(8)) uut (.clock(clock), .rst(rst),
    .pwm_high(pwm_h), .pwm_low(pwm_l), .output_enable(oe), .sleep_mode(slp),
    .short_detect_en(sc_en), .short_threshold_sel(thr_sel), .gate_uv_detect_en(uv_en),
    .dead_time_sel(dt_sel), .blanking_sel(blk_sel), .amp_standby_off(amp_off),
    .high_vds_mv(33'h0), .low_vds_mv({22'h0, vds}), .high_bias_low(3'h0),
    .low_bias_low(lbias), .high_gate_outputs(hg), .low_gate_outputs(lg),
    .fault_pin_i(1'b0), .fault_pin_o(fault_pin_o), .fault_pin_oe(fault_pin_oe),
    .short_fault(short_fault), .gate_uv_fault(gate_uv_fault),
    .status_msg_req(status_msg_req), .standby(standby), .amp_enable(amp_enable));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wait_gate(output int n);
    n = 0;
    while (lg[0] !== 1'b1) begin
      tick(1);
      n++;
      if (n > 400) begin
        fail_count++;
        final_report();
      end
    end
  endtask
  task automatic clear_fault();
    oe = 0;
    tick(1);
    oe = 1;
    tick(2);
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    tick(3);
    rst = 0;
    `CHK("gates_rst", 6'h00, {hg, lg})
    `CHK("amp_rst", 1'b1, amp_enable)
    oe = 1;
    for (int i = 0; i < 9; i++) begin
      mode = rows[i][9:6];
      tick(260);
      `CHK("gates_step", rows[i][5:0], {hg, lg})
    end
    for (int n = 0; n < 8; n++) begin
      mode = 0;
      dt_sel = n[2:0];
      tick(3);
      mode = 1;
      wait_gate(cnt);
      `CHK("dead_time", ((n + 1) * 3125 + 99) / 100 + 1, cnt)
    end
    dt_sel = 0;
    blk_sel = 0;
    sc_en = 1;
    mode = 0;
    tick(3);
    mode = 1;
    wait_gate(cnt);
    vds = 11'h3e8;
    tick(40);
    `CHK("blank_hold", 1'b0, short_fault)
    vds = 0;
    tick(40);
    for (int s = 0; s < 4; s++) begin
      thr_sel = s[1:0];
      vds = 11'((s + 1) * 250);
      tick(4);
      `CHK("at_thr", 1'b0, short_fault)
      vds = vds + 11'h001;
      tick(1);
      `CHK("short_set", 4'he, {short_fault, fault_pin_oe, status_msg_req, fault_pin_o})
      tick(1);
      `CHK("short_off", 7'h00, {hg, lg, status_msg_req})
      vds = 0;
      clear_fault();
      `CHK("short_clr", 1'b0, short_fault)
      wait_gate(cnt);
      tick(70);
    end
    sc_en = 0;
    vds = 11'h7ff;
    tick(5);
    `CHK("short_dis", 1'b0, short_fault)
    vds = 0;
    uv_en = 1;
    lbias = 3'h1;
    tick(6);
    `CHK("uv_early", 1'b0, gate_uv_fault)
    tick(6);
    `CHK("uv_set", 2'h3, {gate_uv_fault, fault_pin_oe})
    lbias = 0;
    clear_fault();
    `CHK("uv_clr", 1'b0, gate_uv_fault)
    wait_gate(cnt);
    mode = 9;
    tick(1);
    `CHK("cross", 6'h00, {hg, lg})
    mode = 0;
    oe = 0;
    tick(25);
    `CHK("standby_amp", 2'h3, {standby, amp_enable})
    amp_off = 1;
    tick(1);
    `CHK("amp_off", 1'b0, amp_enable)
    oe = 1;
    tick(2);
    `CHK("standby_exit", 2'h1, {standby, amp_enable})
    slp = 1;
    mode = 1;
    tick(300);
    `CHK("sleep", 4'h0, {lg, amp_enable})
    slp = 0;
    wait_gate(cnt);
    rst = 1;
    tick(1);
    `CHK("gates_rst2", 9'h000, {hg, lg, short_fault, gate_uv_fault, status_msg_req})
    rst = 0;
    tick(2);
    `CHK("gates_rel", 6'h00, {hg, lg})
    final_report();
  end
endmodule  // test_bldc_gate_control_protection
